// ---- hw/dcd_consts.vh ----
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH
// ----------------------------------------------------------------------
// Wishbone register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DCD_ADR_CMD 4'h0
`define DCD_ADR_STATUS 4'h4
`define DCD_ADR_PARAM 4'h8
`define DCD_ADR_SSIZE 4'hc
// ----------------------------------------------------------------------
// Command codes and masks
// ----------------------------------------------------------------------
`define DCD_MSK_RD 8'hf8
`define DCD_VAL_RD 8'h20
`define DCD_MSK_RND 8'hfd
`define DCD_VAL_RND 8'h61
`define DCD_MSK_WR 8'hf0
`define DCD_VAL_WR 8'h30
`define DCD_MSK_WID 8'hf4
`define DCD_VAL_WID 8'hb0
`define DCD_MSK_SCN 8'hfe
`define DCD_VAL_SCN 8'h40
`define DCD_MSK_FMT 8'hfd
`define DCD_VAL_FMT 8'h51
`define DCD_VAL_FSS 8'hd1
`define DCD_MSK_CC 8'hfb
`define DCD_VAL_CC 8'h08
`define DCD_MSK_SP 8'h68
`define DCD_VAL_SP 8'h00
`define DCD_MSK_LPB 8'hf8
`define DCD_VAL_LPB 8'h88
`define DCD_MSK_SLP 8'hff
`define DCD_VAL_SLP 8'h98
`define DCD_MSK_DMP 8'hf9
`define DCD_VAL_DMP 8'ha9
// ----------------------------------------------------------------------
// Command identifiers
// ----------------------------------------------------------------------
`define DCD_C_NONE 4'h0
`define DCD_C_RD 4'h1
`define DCD_C_RND 4'h2
`define DCD_C_WR 4'h3
`define DCD_C_WID 4'h4
`define DCD_C_SCN 4'h5
`define DCD_C_FMT 4'h6
`define DCD_C_FSS 4'h7
`define DCD_C_CC 4'h8
`define DCD_C_SP 4'h9
`define DCD_C_LPB 4'ha
`define DCD_C_SLP 4'hb
`define DCD_C_DMP 4'hc
// ----------------------------------------------------------------------
// Reset value of the parameter register
// ----------------------------------------------------------------------
`define DCD_PARAM_RST 9'h000
`endif

// ---- hw/dcd_decoder.v ----
// What this block does
// - Decode twelve commands; host port accepts only read, write, format, set parameter.
// - Read sector, read next data, write sector, scan ID codes; T disables retries.
// - Write ID, format track, format sector, compute correction codes with options.
// - Set parameter, load parameter block, dump codes update stored parameters; sleep does not.
// - Multi-sector bit clear handles one sector; set transfers consecutive sectors.
// - Long bit set extends sector by 4 or 7 bytes, no ECC.
// - Write sector target from sector register or first buffer byte.
// - Write ID new ID placed right after or offset from current ID.
// - Write ID pulses mark strobe only when mark option set.
// - Format gap-gate option drops write gate over gaps.
// - Correction always moves syndrome; pattern step skipped when option set.
// - Encoding bit clear gives MFM, set gives NRZ; either gives RLL when K is clear.
// - Relocation bit enables relocation ID searches.
// - ECC length bit picks 4 or 7 byte ECC and extension.
// - Head width bit picks 3 or 4 head select bits.
// - Span bit sets correction span 5, 11 or 22 bits.
// - Sector style bit picks soft or hard sector; hard makes run a pulse.
// - Mode is RLL when K is 0, MFM when Z 0, else NRZ.
// - ECC length ignored in RLL; gap, field, sync options only hard-sector.
// - K clear selects RLL interface and is the reset default.
// - Dump sync option selects FE zero-preset or A1 ones-preset CRC.
// - Dump field option selects two fields or a single field.
// - Custom size option loads sector size from cylinder registers.
//
// The register offsets and register access over Wishbone were left to the implementer.
`default_nettype none
`include "dcd_consts.vh"
module dcd_decoder (
    input wire clk_i,
    input wire rst_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire wb_we_i,
    input wire [3:0] wb_sel_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire host_cmd_we_i,
    input wire [7:0] host_cmd_i,
    input wire [15:0] cylinder_i,
    output reg cmd_valid_o,
    output reg [3:0] cmd_id_o,
    output reg cmd_aborted_o,
    output reg retry_en_o,
    output reg multi_sector_o,
    output reg long_sector_o,
    output reg [2:0] long_ext_bytes_o,
    output reg sector_from_buffer_o,
    output reg id_offset_o,
    output reg mark_write_strobe_en_o,
    output reg gap_gate_o,
    output reg pattern_calc_o,
    output reg dump_ones_crc_o,
    output reg dump_single_field_o,
    output reg [2:0] mode_o,
    output reg [2:0] ecc_bytes_o,
    output reg [4:0] corr_span_o,
    output reg [2:0] head_bits_o,
    output reg reloc_search_o,
    output reg hard_sector_o,
    output reg sector_pulse_sel_o,
    output reg custom_size_o,
    output reg [15:0] sector_size_o
);

// ----------------------------------------------------------------------
// Decoding functions
// ----------------------------------------------------------------------
localparam [2:0] MODE_RLL = 3'b001;
localparam [2:0] MODE_MFM = 3'b010;
localparam [2:0] MODE_NRZ = 3'b100;

function [3:0] dcd_classify;
    input [7:0] c;
    begin
        if ((c & `DCD_MSK_RD) == `DCD_VAL_RD) begin
            dcd_classify = `DCD_C_RD;
        end else if ((c & `DCD_MSK_RND) == `DCD_VAL_RND) begin
            dcd_classify = `DCD_C_RND;
        end else if ((c & `DCD_MSK_WR) == `DCD_VAL_WR) begin
            dcd_classify = `DCD_C_WR;
        end else if ((c & `DCD_MSK_WID) == `DCD_VAL_WID) begin
            dcd_classify = `DCD_C_WID;
        end else if ((c & `DCD_MSK_SCN) == `DCD_VAL_SCN) begin
            dcd_classify = `DCD_C_SCN;
        end else if ((c & `DCD_MSK_FMT) == `DCD_VAL_FMT) begin
            dcd_classify = `DCD_C_FMT;
        end else if ((c & `DCD_MSK_FMT) == `DCD_VAL_FSS) begin
            dcd_classify = `DCD_C_FSS;
        end else if ((c & `DCD_MSK_CC) == `DCD_VAL_CC) begin
            dcd_classify = `DCD_C_CC;
        end else if ((c & `DCD_MSK_SP) == `DCD_VAL_SP) begin
            dcd_classify = `DCD_C_SP;
        end else if ((c & `DCD_MSK_LPB) == `DCD_VAL_LPB) begin
            dcd_classify = `DCD_C_LPB;
        end else if ((c & `DCD_MSK_SLP) == `DCD_VAL_SLP) begin
            dcd_classify = `DCD_C_SLP;
        end else if ((c & `DCD_MSK_DMP) == `DCD_VAL_DMP) begin
            dcd_classify = `DCD_C_DMP;
        end else begin
            dcd_classify = `DCD_C_NONE;
        end
    end
endfunction

// Only five commands are reachable from the host task file.
function dcd_host_ok;
    input [3:0] id;
    begin
        dcd_host_ok = (id == `DCD_C_RD) || (id == `DCD_C_WR) ||
            (id == `DCD_C_FMT) || (id == `DCD_C_FSS) ||
            (id == `DCD_C_SP);
    end
endfunction

// ----------------------------------------------------------------------
// Stored parameters: {U,K,D,S,H,E,R,Z,B} + I
// ----------------------------------------------------------------------
reg z_q, r_q, e_q, h_q, s_q, d_q, k_q, u_q, b_q, i_q;
reg [15:0] ssize_q;
reg [7:0] last_cmd_q;
reg [3:0] last_id_q;
reg abort_q;

wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
wire [3:0] wb_a = wb_adr_i[3:0];
wire micro_go = wb_wr && (wb_a == `DCD_ADR_CMD);
wire [7:0] new_cmd = micro_go ? wb_dat_i[7:0] : host_cmd_i;
wire [3:0] new_id = dcd_classify(new_cmd);
wire host_bad = !micro_go && !dcd_host_ok(new_id);
wire issue = micro_go || host_cmd_we_i;
wire exec = issue && (new_id != `DCD_C_NONE) && !host_bad;
wire rll_now = !k_q;

// ----------------------------------------------------------------------
// Command capture and parameter update
// ----------------------------------------------------------------------
// The microcontroller wins when both parties issue in the same cycle.
always @(posedge clk_i) begin
    if (rst_i) begin
        last_cmd_q <= 8'h00;
        last_id_q <= `DCD_C_NONE;
        abort_q <= 1'b0;
        cmd_valid_o <= 1'b0;
        {z_q, r_q, e_q, h_q, s_q, d_q, k_q, u_q, b_q} <= `DCD_PARAM_RST;
        i_q <= 1'b0;
        ssize_q <= 16'h0000;
    end else begin
        cmd_valid_o <= exec;
        if (issue) begin
            last_cmd_q <= new_cmd;
            last_id_q <= exec ? new_id : `DCD_C_NONE;
            abort_q <= !exec;
        end
        if (exec && new_id == `DCD_C_SP) begin
            z_q <= new_cmd[7];
            r_q <= new_cmd[4];
            e_q <= new_cmd[2];
            h_q <= new_cmd[1];
            s_q <= new_cmd[0];
        end
        if (exec && new_id == `DCD_C_LPB) begin
            d_q <= new_cmd[2];
            k_q <= new_cmd[1];
            u_q <= new_cmd[0];
            if (new_cmd[0]) begin
                ssize_q <= cylinder_i;
            end
        end
        if (exec && new_id == `DCD_C_DMP) begin
            b_q <= new_cmd[2];
            i_q <= new_cmd[1];
        end
    end
end

// ----------------------------------------------------------------------
// Option outputs for the executing command
// ----------------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        cmd_id_o <= `DCD_C_NONE;
        cmd_aborted_o <= 1'b0;
        retry_en_o <= 1'b1;
        multi_sector_o <= 1'b0;
        long_sector_o <= 1'b0;
        sector_from_buffer_o <= 1'b0;
        id_offset_o <= 1'b0;
        mark_write_strobe_en_o <= 1'b0;
        gap_gate_o <= 1'b0;
        pattern_calc_o <= 1'b1;
        dump_ones_crc_o <= 1'b0;
        dump_single_field_o <= 1'b0;
    end else begin
        cmd_id_o <= last_id_q;
        // Aborted stands beside the valid pulse, one edge after the issue.
        cmd_aborted_o <= issue ? !exec : abort_q;
        retry_en_o <= !last_cmd_q[0];
        multi_sector_o <= (last_id_q == `DCD_C_RD ||
            last_id_q == `DCD_C_WR) && last_cmd_q[2];
        long_sector_o <= (last_id_q == `DCD_C_RD ||
            last_id_q == `DCD_C_WR || last_id_q == `DCD_C_RND ||
            last_id_q == `DCD_C_DMP) && last_cmd_q[1];
        sector_from_buffer_o <= (last_id_q == `DCD_C_WR) &&
            last_cmd_q[3];
        id_offset_o <= (last_id_q == `DCD_C_WID) && last_cmd_q[3];
        mark_write_strobe_en_o <= (last_id_q == `DCD_C_WID) &&
            last_cmd_q[1];
        // Hard-sector only options stay off in soft-sector mode.
        gap_gate_o <= (last_id_q == `DCD_C_FMT ||
            last_id_q == `DCD_C_FSS) && last_cmd_q[1] && d_q;
        pattern_calc_o <= !((last_id_q == `DCD_C_CC) && last_cmd_q[2]);
        dump_ones_crc_o <= b_q && d_q;
        dump_single_field_o <= i_q && d_q;
    end
end

// ----------------------------------------------------------------------
// Mode and parameter outputs
// ----------------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        mode_o <= MODE_RLL;
        ecc_bytes_o <= 3'd4;
        long_ext_bytes_o <= 3'd4;
        corr_span_o <= 5'd5;
        head_bits_o <= 3'd3;
        reloc_search_o <= 1'b0;
        hard_sector_o <= 1'b0;
        sector_pulse_sel_o <= 1'b0;
        custom_size_o <= 1'b0;
        sector_size_o <= 16'h0000;
    end else begin
        if (!k_q) begin
            mode_o <= MODE_RLL;
        end else if (!z_q) begin
            mode_o <= MODE_MFM;
        end else begin
            mode_o <= MODE_NRZ;
        end
        // In RLL the length bit is ignored and the short ECC is kept.
        ecc_bytes_o <= (e_q && !rll_now) ? 3'd7 : 3'd4;
        long_ext_bytes_o <= (e_q && !rll_now) ? 3'd7 : 3'd4;
        if (e_q && !rll_now) begin
            corr_span_o <= s_q ? 5'd22 : 5'd11;
        end else begin
            corr_span_o <= s_q ? 5'd11 : 5'd5;
        end
        head_bits_o <= h_q ? 3'd4 : 3'd3;
        reloc_search_o <= r_q;
        hard_sector_o <= d_q;
        sector_pulse_sel_o <= d_q;
        custom_size_o <= u_q;
        sector_size_o <= ssize_q;
    end
end

// ----------------------------------------------------------------------
// Wishbone slave: one wait state, ack for one cycle
// ----------------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= wb_hit;
        wb_dat_o <= 32'h0000_0000;
        if (wb_hit && !wb_we_i) begin
            if (wb_a == `DCD_ADR_CMD) begin
                wb_dat_o <= {24'h000000, last_cmd_q};
            end else if (wb_a == `DCD_ADR_STATUS) begin
                wb_dat_o <= {27'h0, abort_q, last_id_q};
            end else if (wb_a == `DCD_ADR_PARAM) begin
                wb_dat_o <= {22'h0, i_q, b_q, u_q, k_q, d_q,
                    s_q, h_q, e_q, r_q, z_q};
            end else if (wb_a == `DCD_ADR_SSIZE) begin
                wb_dat_o <= {16'h0000, ssize_q};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
end

endmodule // dcd_decoder
`default_nettype wire

// ---- sim/dcd_chk.sv ----
`default_nettype none
module dcd_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic host_cmd_we_i,
    input wire logic [7:0] host_cmd_i,
    input wire logic cmd_valid_o,
    input wire logic [3:0] cmd_id_o,
    input wire logic cmd_aborted_o,
    input wire logic retry_en_o,
    input wire logic multi_sector_o,
    input wire logic long_sector_o,
    input wire logic [2:0] mode_o,
    input wire logic [2:0] ecc_bytes_o,
    input wire logic [4:0] corr_span_o,
    input wire logic [2:0] head_bits_o,
    input wire logic hard_sector_o,
    input wire logic sector_pulse_sel_o
);
    // ------------------------------------------------------------------
    // Command sources
    // ------------------------------------------------------------------
    // The micro port wins a tie, so a host byte only counts without it.
    wire mw = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
        && wb_adr_i[3:0] == 4'h0;
    wire hw = host_cmd_we_i && !mw;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken_rd;
        cmd_valid_o && !cmd_aborted_o ##1 cmd_id_o == 4'h1;
    endsequence
    sequence s_refused;
        cmd_aborted_o && !cmd_valid_o;
    endsequence
    a_host_read:
        assert property (hw && host_cmd_i[7:3] == 5'b00100 |=> s_taken_rd)
        else $error("host read sector not accepted");
    a_host_refuse:
        assert property (hw && host_cmd_i == 8'h61 |=> s_refused)
        else $error("host read next data not refused");
    a_read_opts:
        assert property (hw && host_cmd_i[7:3] == 5'b00100 |-> ##2
            retry_en_o == !$past(host_cmd_i[0], 2)
            && multi_sector_o == $past(host_cmd_i[2], 2)
            && long_sector_o == $past(host_cmd_i[1], 2))
        else $error("read options do not follow the byte");
    a_bad_byte:
        assert property (mw && wb_dat_i[7:0] == 8'hff |=>
            s_refused ##1 cmd_id_o == 4'h0)
        else $error("undefined byte not aborted");
    a_ack_once:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
            wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
    a_mode_hot:
        assert property ($onehot(mode_o))
        else $error("mode not one-hot");
    a_rll_ecc:
        assert property (mode_o == 3'b001 |-> ecc_bytes_o == 3'd4)
        else $error("ecc length not fixed in RLL");
    a_span_ecc:
        assert property ((ecc_bytes_o == 3'd4 && (corr_span_o == 5'd5
            || corr_span_o == 5'd11)) || (ecc_bytes_o == 3'd7
            && (corr_span_o == 5'd11 || corr_span_o == 5'd22)))
        else $error("span does not match ecc length");
    a_pulse_sel:
        assert property (sector_pulse_sel_o == hard_sector_o)
        else $error("run input use differs from sector style");
    a_head_bits:
        assert property (head_bits_o == 3'd3 || head_bits_o == 3'd4)
        else $error("head bit count out of range");
endmodule // dcd_chk
bind dcd_decoder dcd_chk chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .host_cmd_we_i,
    .host_cmd_i, .cmd_valid_o, .cmd_id_o, .cmd_aborted_o, .retry_en_o,
    .multi_sector_o, .long_sector_o, .mode_o, .ecc_bytes_o, .corr_span_o,
    .head_bits_o, .hard_sector_o, .sector_pulse_sel_o);
`default_nettype wire

// ---- sim/dcd_decoder_test.sv ----
`default_nettype none
module dcd_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] CYL = 16'h0a5c;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic req = 1'b0;
    logic [7:0] hb = 8'h00;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;
    wire [31:0] wb_dat_o;
    wire [15:0] cylinder_i, sector_size_o;
    wire [7:0] host_cmd_i;
    wire [4:0] corr_span_o;
    wire [3:0] cmd_id_o;
    wire [2:0] mode_o, ecc_bytes_o, head_bits_o, long_ext_bytes_o;
    wire dump_single_field_o;
    wire wb_ack_o, host_cmd_we_i, cmd_valid_o, cmd_aborted_o, retry_en_o;
    wire multi_sector_o, long_sector_o, sector_from_buffer_o, id_offset_o;
    wire mark_write_strobe_en_o, gap_gate_o, pattern_calc_o;
    wire dump_ones_crc_o, reloc_search_o, hard_sector_o, custom_size_o;
    // Byte in the top half, expected command identity in the low nibble.
    logic [15:0] rows [13] = '{16'h2001, 16'h6102, 16'h3003, 16'hb004,
        16'h4005, 16'h5106, 16'hd107, 16'h0808, 16'h0009, 16'h880a,
        16'h980b, 16'ha90c, 16'hff00};
    dcd_host_model #(.CYL(CYL)) host_m (.clk_i, .req_i(req), .byte_i(hb),
        .cmd_we_o(host_cmd_we_i), .cmd_o(host_cmd_i), .cyl_o(cylinder_i));
    dcd_decoder uut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
        .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .host_cmd_we_i,
        .host_cmd_i, .cylinder_i, .cmd_valid_o, .cmd_id_o, .cmd_aborted_o,
        .retry_en_o, .multi_sector_o, .long_sector_o, .long_ext_bytes_o,
        .sector_from_buffer_o, .id_offset_o, .mark_write_strobe_en_o,
        .gap_gate_o, .pattern_calc_o, .dump_ones_crc_o,
        .dump_single_field_o, .mode_o, .ecc_bytes_o, .corr_span_o,
        .head_bits_o, .reloc_search_o, .hard_sector_o,
        .sector_pulse_sel_o(), .custom_size_o, .sector_size_o);
    always #5 clk_i = ~clk_i;
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_adr_i <= {28'h0, a};
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            $display("mismatch at %0t: bus ack never came", $time);
            test_done();
        end
    endtask
    // Micro command; options stand one edge after the taking edge.
    task automatic cmd(input logic [7:0] b);
        wb(4'h0, 1'b1, {24'h0, b});
        @(posedge clk_i);
        #1;
    endtask
    // Host command; returns while the one-cycle valid pulse stands.
    task automatic host(input logic [7:0] b);
        @(posedge clk_i);
        req <= 1'b1;
        hb <= b;
        @(posedge clk_i);
        req <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(mode_o, 3'b001);
        chk(hard_sector_o, 1'b0);
        chk({ecc_bytes_o, corr_span_o, head_bits_o}, 11'h42b);
        chk(long_ext_bytes_o, 3'd4);
        chk({retry_en_o, pattern_calc_o}, 2'b11);
        wb(4'h8, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            cmd(rows[i][15:8]);
            chk(cmd_id_o, rows[i][3:0]);
            wb(4'h4, 1'b0, 32'h0);
            chk(rd, {rows[i][3:0] == 4'h0, rows[i][3:0]});
        end
        $display("test command table done");
        host(8'h61);
        chk({cmd_valid_o, cmd_aborted_o}, 2'b01);
        host(8'h27);
        chk({cmd_valid_o, cmd_aborted_o}, 2'b10);
        @(posedge clk_i);
        #1;
        chk({retry_en_o, multi_sector_o, long_sector_o}, 3'b011);
        $display("test host port done");
        cmd(8'h97);
        chk({mode_o, ecc_bytes_o}, 6'o14);
        chk({corr_span_o, head_bits_o}, 8'h5c);
        chk(reloc_search_o, 1'b1);
        cmd(8'h8f);
        chk({mode_o, ecc_bytes_o}, 6'o47);
        chk({corr_span_o, hard_sector_o, custom_size_o}, 7'h5b);
        chk(sector_size_o, CYL);
        chk(long_ext_bytes_o, 3'd7);
        cmd(8'h53);
        chk(gap_gate_o, 1'b1);
        cmd(8'h38);
        chk(sector_from_buffer_o, 1'b1);
        cmd(8'hba);
        chk({id_offset_o, mark_write_strobe_en_o}, 2'b11);
        cmd(8'h0c);
        chk(pattern_calc_o, 1'b0);
        cmd(8'haf);
        chk(dump_ones_crc_o, 1'b1);
        chk(dump_single_field_o, 1'b1);
        cmd(8'h10);
        chk({mode_o, ecc_bytes_o}, 6'o24);
        chk({corr_span_o, head_bits_o}, 8'h2b);
        wb(4'h2, 1'b0, 32'h0);
        chk(rd, 32'h0);
        $display("test parameters done");
        test_done();
    end
endmodule // dcd_decoder_test
`default_nettype wire

// ---- sim/dcd_host_model.sv ----
`default_nettype none
module dcd_host_model #(
    parameter logic [15:0] CYL = 16'h0a5c
) (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [7:0] byte_i,
    output logic cmd_we_o,
    output logic [7:0] cmd_o,
    output logic [15:0] cyl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Task file command write
    // ------------------------------------------------------------------
    initial cmd_we_o = 1'b0;
    initial cmd_o = 8'h5a;
    // Off the strobe the byte lines keep changing, so the decoder may not
    // lean on a stale byte.
    always @(posedge clk_i) begin
        cmd_we_o <= req_i;
        cmd_o <= req_i ? byte_i : ~cmd_o;
    end
    assign cyl_o = CYL;
endmodule // dcd_host_model
`default_nettype wire
